// ==== src/rtt_timer.sv ====
// How it works
// - Split bit clear gives one 16-bit auto-reload up-counter.
// - 16-bit wrap from all ones loads reload value, sets high flag.
// - Timer irq enable requests interrupt on every 16-bit overflow.
// - With low irq enable too, low byte wraps also request interrupt.
// - Count source is core clock, core clock/12, or external/8.
// - External oscillator is synchronised before its divided tick counts.
// - Split bit set gives two 8-bit counters, each with own reload.
// - In split mode run bit gates high byte only; low always runs.
// - Per-byte select picks core clock, else shared external select decides.
// - In split mode each byte wrap sets its own overflow flag.
// - Split irq on high overflow; with low enable, on either.
// - Flags never cleared by hardware; software clears them.
`default_nettype none
module rtt_timer
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_osc,
    output logic             irq_request
);
    // Count source select, shared by both bytes
    function automatic logic pick_tick(input logic core_sel,
                                       input logic xclk,
                                       input logic t12,
                                       input logic t8);
        pick_tick = core_sel ? 1'b1 : (xclk ? t8 : t12);
    endfunction

    logic [7:0]  ctrl_q;
    logic [7:0]  clk_ctl_q;
    logic [7:0]  rld_lo_q;
    logic [7:0]  rld_hi_q;
    logic [7:0]  cnt_lo_q;
    logic [7:0]  cnt_hi_q;
    logic [7:0]  cnt_lo_d;
    logic [7:0]  cnt_hi_d;
    logic [7:0]  ctrl_d;
    logic [3:0]  div12_q;
    logic [2:0]  div8_q;
    logic        ext_s1_q;
    logic        ext_s2_q;
    logic        ext_s3_q;
    logic        wr_pend_q;
    logic [9:0]  wr_idx_q;
    logic [31:0] hrdata_q;
    logic        hready_q;
    logic        hresp_q;
    logic        irq_q;

    // Bus decode
    wire         addr_phase = hsel & hready & htrans[1];
    wire  [9:0]  a_idx      = haddr[11:2];
    wire  [7:0]  rd_byte    =
        (a_idx == rtt_pkg::IDX_CTRL)    ? (ctrl_q & rtt_pkg::CTRL_RD_MASK) :
        (a_idx == rtt_pkg::IDX_RLD_LO)  ? rld_lo_q :
        (a_idx == rtt_pkg::IDX_RLD_HI)  ? rld_hi_q :
        (a_idx == rtt_pkg::IDX_CNT_LO)  ? cnt_lo_q :
        (a_idx == rtt_pkg::IDX_CNT_HI)  ? cnt_hi_q :
        (a_idx == rtt_pkg::IDX_CLK_CTL) ? clk_ctl_q :
        rtt_pkg::RESET_BYTE;
    wire  [7:0]  wbyte      = hwdata[7:0];
    wire         wr_ctrl    = wr_pend_q & (wr_idx_q == rtt_pkg::IDX_CTRL);
    wire         wr_rl      = wr_pend_q & (wr_idx_q == rtt_pkg::IDX_RLD_LO);
    wire         wr_rh      = wr_pend_q & (wr_idx_q == rtt_pkg::IDX_RLD_HI);
    wire         wr_cl      = wr_pend_q & (wr_idx_q == rtt_pkg::IDX_CNT_LO);
    wire         wr_ch      = wr_pend_q & (wr_idx_q == rtt_pkg::IDX_CNT_HI);
    wire         wr_clk     = wr_pend_q & (wr_idx_q == rtt_pkg::IDX_CLK_CTL);

    // Control fields
    wire         split    = ctrl_q[rtt_pkg::BIT_SPLIT];
    wire         run      = ctrl_q[rtt_pkg::BIT_RUN];
    wire         xclk     = ctrl_q[rtt_pkg::BIT_XCLK];
    wire         lo_irqen = ctrl_q[rtt_pkg::BIT_LO_IRQEN];
    wire         hi_flag  = ctrl_q[rtt_pkg::BIT_HI_FLAG];
    wire         lo_flag  = ctrl_q[rtt_pkg::BIT_LO_FLAG];
    wire         irq_en   = clk_ctl_q[rtt_pkg::BIT_IRQ_EN];

    // Prescaler ticks
    wire         tick12   = (div12_q == rtt_pkg::DIV_CORE_END);
    // Only the second and third stages feed the edge detector
    wire         ext_rise = ext_s2_q & ~ext_s3_q;
    wire         tick8    = ext_rise & (div8_q == rtt_pkg::DIV_EXT_END);
    wire         tick_lo  = pick_tick(clk_ctl_q[rtt_pkg::BIT_LO_CSEL],
                                      xclk, tick12, tick8);
    wire         tick_hi  = pick_tick(clk_ctl_q[rtt_pkg::BIT_HI_CSEL],
                                      xclk, tick12, tick8);

    // Counting; in 16-bit mode the high select clocks the whole word
    wire         tick16   = ~split & run & tick_hi;
    wire         lo_full  = (cnt_lo_q == rtt_pkg::BYTE_ONES);
    wire         hi_full  = (cnt_hi_q == rtt_pkg::BYTE_ONES);
    wire         inc_lo   = split ? tick_lo : tick16;
    wire         inc_hi   = split ? (run & tick_hi) : (tick16 & lo_full);
    wire         lo_wrap  = inc_lo & lo_full;
    wire         hi_wrap  = inc_hi & hi_full;
    wire         lo_reld  = split ? lo_wrap : hi_wrap;
    wire  [7:0]  lo_inc_v = cnt_lo_q + 8'h01;
    wire  [7:0]  hi_inc_v = cnt_hi_q + 8'h01;

    // A bus write to a count byte takes precedence over counting
    assign cnt_lo_d = wr_cl   ? wbyte    :
                      lo_reld ? rld_lo_q :
                      inc_lo  ? lo_inc_v : cnt_lo_q;
    assign cnt_hi_d = wr_ch   ? wbyte    :
                      hi_wrap ? rld_hi_q :
                      inc_hi  ? hi_inc_v : cnt_hi_q;

    // Flags: a set in the clearing cycle wins
    wire  [7:0]  ctrl_w   = wr_ctrl ? (wbyte & rtt_pkg::CTRL_RD_MASK)
                                    : ctrl_q;
    assign ctrl_d = ctrl_w
                  | ({7'h00, hi_wrap} << rtt_pkg::BIT_HI_FLAG)
                  | ({7'h00, lo_wrap} << rtt_pkg::BIT_LO_FLAG);

    // Same equation serves both modes; software must sort the source
    wire         irq_d = irq_en & (hi_flag | (lo_irqen & lo_flag));

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q    <= rtt_pkg::RESET_BYTE;
            clk_ctl_q <= rtt_pkg::RESET_BYTE;
            rld_lo_q  <= rtt_pkg::RESET_BYTE;
            rld_hi_q  <= rtt_pkg::RESET_BYTE;
            cnt_lo_q  <= rtt_pkg::RESET_BYTE;
            cnt_hi_q  <= rtt_pkg::RESET_BYTE;
            irq_q     <= 1'b0;
        end
        else
        begin
            ctrl_q    <= ctrl_d;
            clk_ctl_q <= wr_clk ? (wbyte & rtt_pkg::CLK_RD_MASK) : clk_ctl_q;
            rld_lo_q  <= wr_rl ? wbyte : rld_lo_q;
            rld_hi_q  <= wr_rh ? wbyte : rld_hi_q;
            cnt_lo_q  <= cnt_lo_d;
            cnt_hi_q  <= cnt_hi_d;
            irq_q     <= irq_d;
        end
    end

    // Prescalers and external synchroniser
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            div12_q  <= 4'h0;
            div8_q   <= 3'h0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end
        else
        begin
            div12_q  <= tick12 ? 4'h0 : div12_q + 4'h1;
            div8_q   <= ext_rise ? div8_q + 3'h1 : div8_q;
            ext_s1_q <= ext_osc;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // Zero-wait slave: read data registered in the address phase
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 10'h000;
            hrdata_q  <= 32'h0000_0000;
            // Ready stays high in reset so the bus never stalls on us
            hready_q  <= 1'b1;
            hresp_q   <= 1'b0;
        end
        else
        begin
            hready_q  <= 1'b1;
            hresp_q   <= 1'b0;
            wr_pend_q <= addr_phase & hwrite;
            wr_idx_q  <= a_idx;
            hrdata_q  <= (addr_phase & ~hwrite) ? {24'h000000, rd_byte}
                                                : hrdata_q;
        end
    end

    assign hrdata      = hrdata_q;
    assign hreadyout   = hready_q;
    assign hresp       = hresp_q;
    assign irq_request = irq_q;

    // Assertions
    a_hi_wrap_reload: assert property (@(posedge core_clk) disable iff (rst)
        (~split & tick16 & lo_full & hi_full & ~wr_pend_q)
        |=> (cnt_lo_q == $past(rld_lo_q)) && (cnt_hi_q == $past(rld_hi_q))
            && hi_flag)
        else $error("16-bit wrap did not reload or set high flag");
    a_stop_hold: assert property (@(posedge core_clk) disable iff (rst)
        (~split & ~run & ~wr_pend_q) |=> $stable(cnt_hi_q) && $stable(cnt_lo_q))
        else $error("16-bit counter moved while stopped");
    a_lo_free_run: assert property (@(posedge core_clk) disable iff (rst)
        (split & ~run & tick_lo & ~lo_full & ~wr_pend_q)
        |=> cnt_lo_q == $past(cnt_lo_q) + 8'h01)
        else $error("Split low byte did not count");
    a_split_hi_hold: assert property (@(posedge core_clk) disable iff (rst)
        (split & ~run & ~wr_pend_q) |=> $stable(cnt_hi_q))
        else $error("Split high byte counted while stopped");
    a_lo_flag_set: assert property (@(posedge core_clk) disable iff (rst)
        (inc_lo & lo_full) |=> lo_flag)
        else $error("Low wrap did not set low flag");
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
        (hi_flag & ~wr_ctrl) |=> hi_flag)
        else $error("High flag cleared without software");
    a_irq_follow: assert property (@(posedge core_clk) disable iff (rst)
        (irq_en & lo_irqen & lo_flag) |=> irq_request)
        else $error("Low overflow did not request interrupt");
    a_irq_gate: assert property (@(posedge core_clk) disable iff (rst)
        (~irq_en) |=> ~irq_request)
        else $error("Interrupt requested while disabled");
    a_div12_gap: assert property (@(posedge core_clk) disable iff (rst)
        tick12 |=> ~tick12 [*8] ##1 ~tick12 ##1 ~tick12 ##1 ~tick12 ##1 tick12)
        else $error("Core divide by twelve out of step");
    a_unused_zero: assert property (@(posedge core_clk) disable iff (rst)
        (addr_phase & ~hwrite & (a_idx == rtt_pkg::IDX_CTRL))
        |=> (hrdata[4] == 1'b0) && (hrdata[1] == 1'b0))
        else $error("Unused control bits read non-zero");
    a_split_lo_reload: assert property (@(posedge core_clk) disable iff (rst)
        (split & tick_lo & lo_full & ~wr_pend_q)
        |=> cnt_lo_q == $past(rld_lo_q))
        else $error("Split low byte did not reload");
    a_split_hi_reload: assert property (@(posedge core_clk) disable iff (rst)
        (split & run & tick_hi & hi_full & ~wr_pend_q)
        |=> cnt_hi_q == $past(rld_hi_q))
        else $error("Split high byte did not reload");
    a_split_hi_flag: assert property (@(posedge core_clk) disable iff (rst)
        (split & run & tick_hi & hi_full)
        |=> hi_flag)
        else $error("Split high wrap did not set high flag");
    a_split_lo_flag: assert property (@(posedge core_clk) disable iff (rst)
        (split & tick_lo & lo_full)
        |=> lo_flag)
        else $error("Split low wrap did not set low flag");
    a_irq_hi_flag: assert property (@(posedge core_clk) disable iff (rst)
        (irq_en & hi_flag)
        |=> irq_request)
        else $error("High overflow did not request interrupt");
    a_irq_lo_gate: assert property (@(posedge core_clk) disable iff (rst)
        (~hi_flag & ~lo_irqen)
        |=> ~irq_request)
        else $error("Low overflow requested interrupt while masked");
    a_lo_sticky: assert property (@(posedge core_clk) disable iff (rst)
        (lo_flag & ~wr_ctrl)
        |=> lo_flag)
        else $error("Low flag cleared without software");
    a_unused_write: assert property (@(posedge core_clk) disable iff (rst)
        wr_ctrl
        |=> (ctrl_q[4] == 1'b0) && (ctrl_q[1] == 1'b0))
        else $error("Unused control bits took a write");
    a_core_step: assert property (@(posedge core_clk) disable iff (rst)
        (~split & run & clk_ctl_q[rtt_pkg::BIT_HI_CSEL] & ~lo_full & ~wr_pend_q)
        |=> cnt_lo_q == $past(cnt_lo_q) + 8'h01)
        else $error("Core clock did not advance the counter");
    a_carry_hi: assert property (@(posedge core_clk) disable iff (rst)
        (~split & tick16 & lo_full & ~hi_full & ~wr_pend_q)
        |=> (cnt_hi_q == $past(cnt_hi_q) + 8'h01) && (cnt_lo_q == 8'h00))
        else $error("Low byte carry did not reach high byte");
    a_hi_no_carry: assert property (@(posedge core_clk) disable iff (rst)
        (~split & tick16 & ~lo_full & ~wr_pend_q)
        |=> $stable(cnt_hi_q))
        else $error("High byte moved without a carry");
    a_ext_div_step: assert property (@(posedge core_clk) disable iff (rst)
        ext_rise
        |=> div8_q == $past(div8_q) + 3'h1)
        else $error("Synchronised edge did not advance divider");
    a_ext_quiet: assert property (@(posedge core_clk) disable iff (rst)
        (~ext_s2_q | ext_s3_q)
        |=> $stable(div8_q))
        else $error("External divider moved without an edge");
    a_rd_upper_zero: assert property (@(posedge core_clk) disable iff (rst)
        (addr_phase & ~hwrite)
        |=> hrdata[31:8] == 24'h000000)
        else $error("Read data upper bits non-zero");
    a_div12_wrap: assert property (@(posedge core_clk) disable iff (rst)
        tick12
        |=> div12_q == 4'h0)
        else $error("Core divider did not restart");
endmodule // rtt_timer
`default_nettype wire

// ==== src/rtt_pkg.sv ====
`default_nettype none
package rtt_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL     = 10'h0c8;
    localparam logic [9:0] IDX_RLD_LO   = 10'h0ca;
    localparam logic [9:0] IDX_RLD_HI   = 10'h0cb;
    localparam logic [9:0] IDX_CNT_LO   = 10'h0cc;
    localparam logic [9:0] IDX_CNT_HI   = 10'h0cd;
    localparam logic [9:0] IDX_CLK_CTL  = 10'h0ce;

    // Control register fields
    localparam int BIT_HI_FLAG  = 7;
    localparam int BIT_LO_FLAG  = 6;
    localparam int BIT_LO_IRQEN = 5;
    localparam int BIT_SPLIT    = 3;
    localparam int BIT_RUN      = 2;
    localparam int BIT_XCLK     = 0;
    localparam logic [7:0] CTRL_RD_MASK = 8'hed;

    // Clock control register fields
    localparam int BIT_LO_CSEL  = 0;
    localparam int BIT_HI_CSEL  = 1;
    localparam int BIT_IRQ_EN   = 2;
    localparam logic [7:0] CLK_RD_MASK  = 8'h07;

    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [7:0] BYTE_ONES    = 8'hff;

    // Prescalers
    localparam int          DIV_CORE     = 12;
    localparam logic [3:0]  DIV_CORE_END = 4'(DIV_CORE - 1);
    localparam int          DIV_EXT      = 8;
    localparam logic [2:0]  DIV_EXT_END  = 3'(DIV_EXT - 1);

    localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h2;
endpackage : rtt_pkg
`default_nettype wire

// ==== bench/tb_top.sv ====
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst, hsel, hwrite, ext_osc;
    logic [31:0] haddr, hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, irq_request;
    int          err_count, total_checks, cycles;
    int          seed = 61123;
    logic [7:0]  v, rh;
    logic [31:0] r;
    // Expected register contents, kept from the write side only
    logic [7:0]  mdl [int];

    rtt_timer i_dut (.core_clk(core_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_osc(ext_osc),
        .irq_request(irq_request));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One whole-word transfer; waits on hready at each phase
    task automatic bus(input logic [9:0] idx, input logic wr,
                       input logic [7:0] wd, output logic [7:0] rd);
        hsel   <= 1'b1;
        haddr  <= {20'h0, idx, 2'h0};
        htrans <= rtt_pkg::HTRANS_NONSEQ_BIT;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
        if (wr)
            mdl[idx] = wd;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus(idx, 1'b1, wd, d);
    endtask

    task automatic rd(input logic [9:0] idx, output logic [7:0] d);
        bus(idx, 1'b0, 8'h00, d);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    initial
    begin
        rst = 1'b1; hsel = 1'b0; hwrite = 1'b0; ext_osc = 1'b0;
        haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hsize = 3'h2;
        idle(4);
        rst <= 1'b0;
        idle(1);
        rd(rtt_pkg::IDX_CTRL, v);     chk(v, 8'h00);
        rd(rtt_pkg::IDX_CLK_CTL, v);  chk(v, 8'h00);
        rd(10'h010, v);               chk(v, 8'h00);
        chk({6'h0, hreadyout, hresp}, 8'h02);
        wr(rtt_pkg::IDX_CTRL, 8'hd2);
        idle(6);
        rd(rtt_pkg::IDX_CTRL, v);     chk(v, mdl[rtt_pkg::IDX_CTRL] & 8'hed);
        wr(rtt_pkg::IDX_CTRL, 8'h00);
        rd(rtt_pkg::IDX_CTRL, v);     chk(v, 8'h00);
        // Random reload high byte; low reload zero keeps it unambiguous
        r  = $random(seed);
        rh = r[7:0];
        wr(rtt_pkg::IDX_RLD_LO, 8'h00);
        wr(rtt_pkg::IDX_RLD_HI, rh);
        wr(rtt_pkg::IDX_CNT_LO, 8'hf0);
        wr(rtt_pkg::IDX_CNT_HI, 8'hff);
        wr(rtt_pkg::IDX_CLK_CTL, 8'h06);
        wr(rtt_pkg::IDX_CTRL, 8'h04);
        idle(30);
        rd(rtt_pkg::IDX_CTRL, v);     chk(v, 8'hc4);
        chk({7'h0, irq_request}, 8'h01);
        rd(rtt_pkg::IDX_CNT_HI, v);   chk(v, rh);
        wr(rtt_pkg::IDX_CTRL, 8'h00);
        idle(2);
        chk({7'h0, irq_request}, 8'h00);
        wr(rtt_pkg::IDX_CNT_LO, 8'hf8);
        wr(rtt_pkg::IDX_CTRL, 8'h24);
        idle(12);
        // A high byte of all ones wraps the whole word here as well
        rd(rtt_pkg::IDX_CTRL, v);     chk(v, (rh == 8'hff) ? 8'he4 : 8'h64);
        chk({7'h0, irq_request}, 8'h01);
        // Split mode, high byte stopped while low byte keeps running
        wr(rtt_pkg::IDX_CTRL, 8'h08);
        wr(rtt_pkg::IDX_RLD_LO, 8'hf0);
        wr(rtt_pkg::IDX_RLD_HI, 8'hf0);
        wr(rtt_pkg::IDX_CNT_HI, 8'hfe);
        wr(rtt_pkg::IDX_CNT_LO, 8'hfe);
        wr(rtt_pkg::IDX_CLK_CTL, 8'h07);
        idle(10);
        rd(rtt_pkg::IDX_CTRL, v);     chk(v, 8'h48);
        chk({7'h0, irq_request}, 8'h00);
        rd(rtt_pkg::IDX_CNT_HI, v);   chk(v, 8'hfe);
        rd(rtt_pkg::IDX_CNT_LO, v);   chk(v & 8'hf0, 8'hf0);
        wr(rtt_pkg::IDX_CTRL, 8'h6c);
        idle(10);
        chk({7'h0, irq_request}, 8'h01);
        rd(rtt_pkg::IDX_CTRL, v);     chk(v, 8'hec);
        rd(rtt_pkg::IDX_CNT_HI, v);   chk(v & 8'hf0, 8'hf0);
        // Divide by twelve: about ten ticks in 120 cycles
        wr(rtt_pkg::IDX_CTRL, 8'h08);
        wr(rtt_pkg::IDX_CLK_CTL, 8'h04);
        wr(rtt_pkg::IDX_CNT_LO, 8'h00);
        idle(120);
        rd(rtt_pkg::IDX_CNT_LO, v);
        chk({7'h0, v >= 8'd9 && v <= 8'd11}, 8'h01);
        // External source: sixteen rising edges give two ticks
        wr(rtt_pkg::IDX_CTRL, 8'h09);
        wr(rtt_pkg::IDX_CNT_LO, 8'h00);
        repeat (16)
        begin
            ext_osc <= 1'b1;
            idle(2);
            ext_osc <= 1'b0;
            idle(2);
        end
        idle(8);
        rd(rtt_pkg::IDX_CNT_LO, v);   chk(v, 8'h02);
        rd(rtt_pkg::IDX_CNT_HI, v);   chk(v & 8'hf0, 8'hf0);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
